//--- bench/lmx_host.sv
// host model: issues one byte request at a time to the map
// assumes lmx_pkg; ack and read data stand just after the edge that takes the request
`timescale 1ns/1ns
`default_nettype none
module lmx_host
  import lmx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       ack,
  input  wire logic [7:0] rd_data,
  output var  lmx_req_t   req
);
  initial req = '0;
  // spi carries its page field, i2c relies on page select
  task automatic xfer(input logic w, s, input logic [3:0] pg,
                      input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk);
    req <= '{1'b1, w, s, pg, a, d};
    @(posedge clk);
    // released lines stop showing the last value
    req <= '{1'b0, ~w, ~s, ~pg, ~a, ~d};
    #1;
    q = (ack === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
// testbench: register map driven through the host model
// assumes lmx_pkg, lmx_regmap and lmx_host compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench
  import lmx_pkg::*;
;
  logic        clk, nrst, ack, page_sel, det_load, duty_rd_page;
  lmx_req_t    req;
  lmx_ctl_t    ctl;
  lmx_fault_t  fault_evt;
  logic [7:0]  rd_data, duty_rd_addr, duty_rd_data, q;
  logic [47:0] det_result;
  int          fail_count, checked;
  logic [7:0]  rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h04, 8'h20, 8'h00, 8'h00};
  logic [7:0]  da [6] = '{8'h01, 8'h29, 8'hA0, 8'hC9, 8'hD0, 8'hEC};

  lmx_regmap lmx_regmap_i (.clk(clk), .nrst(nrst), .req(req), .ack(ack), .rd_data(rd_data),
    .page_sel(page_sel), .ctl(ctl), .fault_evt(fault_evt), .det_load(det_load),
    .det_result(det_result), .duty_rd_page(duty_rd_page), .duty_rd_addr(duty_rd_addr),
    .duty_rd_data(duty_rd_data));
  lmx_host lmx_host_i (.clk(clk), .ack(ack), .rd_data(rd_data), .req(req));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic s, input logic [3:0] pg, input logic [7:0] a, d);
    lmx_host_i.xfer(1'b1, s, pg, a, d, q);
  endtask
  task automatic rd(input logic s, input logic [3:0] pg, input logic [7:0] a, exp);
    lmx_host_i.xfer(1'b0, s, pg, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic defaults;
    for (int i = 0; i < 10; i++) rd(1'b1, 4'h0, 8'hF0 + 8'(i), rv[i]);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(3000 * 100);
    fail_count++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    fault_evt = '0;
    det_load = 1'b0;
    det_result = '0;
    duty_rd_page = 1'b0;
    duty_rd_addr = 8'h00;
    fail_count = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    defaults();
    for (int i = 0; i < 10; i++) begin
      wr(1'b0, 4'h0, 8'hF0 + 8'(i), 8'hA0 + 8'(i));
      rd(1'b0, 4'h0, 8'hF0 + 8'(i), (i == 4) ? 8'h00 : 8'hA0 + 8'(i));
    end
    chk(ctl.pull, 8'hA5);
    foreach (da[i]) begin
      wr(1'b0, 4'h0, da[i], da[i] ^ 8'h5A);
      rd(1'b0, 4'h0, da[i], da[i] ^ 8'h5A);
    end
    foreach (da[i]) rd(1'b1, 4'h0, da[i], da[i] ^ 8'h5A);
    wr(1'b1, 4'h1, 8'h01, 8'h77);
    wr(1'b1, 4'h1, 8'hB1, 8'h3C);
    rd(1'b1, 4'h1, 8'h01, 8'h77);
    rd(1'b1, 4'h1, 8'hB1, 8'h3C);
    rd(1'b1, 4'h0, 8'h01, 8'h5B);
    rd(1'b1, 4'h2, 8'h01, 8'h00);
    @(posedge clk) duty_rd_addr <= 8'hEC;
    repeat (2) @(posedge clk);
    #1 chk(duty_rd_data, 8'hB6);
    wr(1'b0, 4'h0, 8'hEF, 8'hFF);
    rd(1'b0, 4'h0, 8'hEF, 8'h00);
    wr(1'b0, 4'h0, 8'hFA, 8'hFF);
    rd(1'b0, 4'h0, 8'hFA, 8'h00);
    wr(1'b0, 4'h0, 8'hE7, 8'h01);
    rd(1'b0, 4'h0, 8'h01, 8'h5B);
    wr(1'b0, 4'h0, 8'hE8, 8'hC5);
    wr(1'b0, 4'h0, 8'hE7, 8'h01);
    chk({7'h00, page_sel}, 8'h01);
    rd(1'b0, 4'h0, 8'h01, 8'h77);
    wr(1'b0, 4'h0, 8'hE7, 8'h00);
    chk({7'h00, page_sel}, 8'h01);
    wr(1'b0, 4'h0, 8'hE8, 8'hC5);
    wr(1'b0, 4'h0, 8'hE7, 8'h03);
    chk({7'h00, page_sel}, 8'h01);
    rd(1'b0, 4'h0, 8'hE8, 8'h00);
    @(posedge clk) fault_evt <= 4'h5;
    @(posedge clk) fault_evt <= '0;
    rd(1'b1, 4'h0, 8'hEF, 8'h05);
    @(posedge clk) det_result <= 48'hF1E2D3C4B5A6;
    det_load <= 1'b1;
    @(posedge clk) det_load <= 1'b0;
    rd(1'b1, 4'h0, 8'hFA, 8'hA6);
    rd(1'b1, 4'h0, 8'hFF, 8'hF1);
    wr(1'b1, 4'h1, 8'hFF, 8'h00);
    rd(1'b1, 4'h0, 8'hF5, 8'hA5);
    wr(1'b1, 4'h0, 8'hF0, 8'h08);
    wr(1'b1, 4'h1, 8'hFF, 8'h00);
    chk({7'h00, page_sel}, 8'h00);
    defaults();
    rd(1'b1, 4'h0, 8'h01, 8'h00);
    rd(1'b1, 4'h0, 8'hEF, 8'h00);
    rd(1'b1, 4'h1, 8'hFF, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- hdl/lmx_map.svh
// register offsets, reset values and keys of the led matrix register map
// assumes nothing; definitions only
`ifndef LMX_MAP_SVH
`define LMX_MAP_SVH
`define LMX_PG0        4'h0
`define LMX_PG1        4'h1
`define LMX_A_PGSEL    8'hE7
`define LMX_A_LOCK     8'hE8
`define LMX_LOCK_KEY   8'hC5
`define LMX_A_FAULT    8'hEF
`define LMX_A_CFG      8'hF0
`define LMX_A_GCC_R    8'hF1
`define LMX_A_GCC_G    8'hF2
`define LMX_A_GCC_B    8'hF3
`define LMX_A_PULL     8'hF5
`define LMX_A_FREQ     8'hF6
`define LMX_A_SPRD     8'hF7
`define LMX_A_DGT      8'hF8
`define LMX_A_DETEN    8'hF9
`define LMX_A_RES_LO   8'hFA
`define LMX_A_RES_HI   8'hFF
`define LMX_A_SRST     8'hFF
`define LMX_DUTY_FIRST 8'h01
`define LMX_P0_LAST    8'hEC
`define LMX_P1_LAST    8'hB1
`define LMX_RST_ZERO   8'h00
`define LMX_RST_PULL   8'h08
`define LMX_RST_FREQ   8'h04
`define LMX_RST_SPRD   8'h20
`define LMX_CFG_RP     3
`endif

//--- hdl/lmx_pkg.sv
// types shared by the led matrix register map
// needs nothing from lmx_map.svh; types use literal widths
`default_nettype none
package lmx_pkg;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       spi;
    logic [3:0] spi_page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmx_req_t;

  typedef struct packed {
    logic [7:0] op_cfg;
    logic [7:0] gcc_r;
    logic [7:0] gcc_g;
    logic [7:0] gcc_b;
    logic [7:0] pull;
    logic [7:0] freq;
    logic [7:0] sprd;
    logic [7:0] dgt;
    logic [7:0] det_en;
  } lmx_ctl_t;

  typedef struct packed {
    logic over_temp;
    logic over_curr;
    logic led_short;
    logic led_open;
  } lmx_fault_t;
endpackage
`default_nettype wire

//--- hdl/lmx_regmap.sv
// led matrix register map: duty bytes, control, status, page select
// assumes a serial front end that turns i2c or spi frames into req
`timescale 1ns/1ns
`default_nettype none
`include "lmx_map.svh"

module lmx_regmap
  import lmx_pkg::*;
#(
  parameter logic [7:0] P0_LAST = `LMX_P0_LAST,
  parameter logic [7:0] P1_LAST = `LMX_P1_LAST
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire lmx_req_t    req,
  output logic             ack,
  output logic [7:0]       rd_data,
  output logic             page_sel,
  output lmx_ctl_t         ctl,
  input  wire lmx_fault_t  fault_evt,
  input  wire logic        det_load,
  input  wire logic [47:0] det_result,
  input  wire logic        duty_rd_page,
  input  wire logic [7:0]  duty_rd_addr,
  output logic [7:0]       duty_rd_data
);

  if (P0_LAST >= `LMX_A_FAULT || P0_LAST < `LMX_DUTY_FIRST ||
      P1_LAST >= `LMX_A_SRST || P1_LAST < `LMX_DUTY_FIRST) begin : g_chk
    $error("duty range parameters out of map");
  end

  // storage
  logic [7:0]  duty0_reg [1:P0_LAST];
  logic [7:0]  duty1_reg [1:P1_LAST];
  lmx_ctl_t    ctl_reg;
  lmx_ctl_t    ctl_next;
  logic [3:0]  fault_reg;
  logic [47:0] det_reg;
  logic        pgsel_reg;
  logic [7:0]  lock_reg;
  logic        ack_reg;
  logic [7:0]  rd_reg;
  logic [7:0]  rd_next;
  logic [7:0]  drd_reg;

  // duty byte addresses, with the i2c command slots kept out
  function automatic logic duty_hit(input logic [7:0] a, input logic [7:0] last);
    duty_hit = a >= `LMX_DUTY_FIRST && a <= last &&
               a != `LMX_A_PGSEL && a != `LMX_A_LOCK;
  endfunction

  // page resolution
  wire [3:0] page    = req.spi ? req.spi_page : {3'h0, pgsel_reg};
  wire       pg0     = page == `LMX_PG0;
  wire       pg1     = page == `LMX_PG1;
  wire       wr      = req.valid & req.write;
  wire [7:0] a       = req.addr;
  wire       cmd_sel = ~req.spi & a == `LMX_A_PGSEL;
  wire       cmd_lk  = ~req.spi & a == `LMX_A_LOCK;
  wire       unlock  = lock_reg == `LMX_LOCK_KEY;
  wire       hit_d0  = pg0 & duty_hit(a, P0_LAST) & ~(cmd_sel | cmd_lk);
  wire       hit_d1  = pg1 & duty_hit(a, P1_LAST) & ~(cmd_sel | cmd_lk);
  wire       hit_res = pg0 & a >= `LMX_A_RES_LO;
  wire [2:0] res_idx = 3'(a - `LMX_A_RES_LO);
  wire       srst    = wr & pg1 & a == `LMX_A_SRST & ctl_reg.op_cfg[`LMX_CFG_RP];
  wire       sel_wr  = wr & cmd_sel;
  wire       sel_ok  = sel_wr & unlock & (req.wdata == 8'h00 || req.wdata == 8'h01);
  wire       dr0_ok  = duty_hit(duty_rd_addr, P0_LAST);
  wire       dr1_ok  = duty_hit(duty_rd_addr, P1_LAST);

  // control register writes
  always_comb begin
    ctl_next = ctl_reg;
    if (wr & pg0) begin
      case (a)
        `LMX_A_CFG:   ctl_next.op_cfg = req.wdata;
        `LMX_A_GCC_R: ctl_next.gcc_r  = req.wdata;
        `LMX_A_GCC_G: ctl_next.gcc_g  = req.wdata;
        `LMX_A_GCC_B: ctl_next.gcc_b  = req.wdata;
        `LMX_A_PULL:  ctl_next.pull   = req.wdata;
        `LMX_A_FREQ:  ctl_next.freq   = req.wdata;
        `LMX_A_SPRD:  ctl_next.sprd   = req.wdata;
        `LMX_A_DGT:   ctl_next.dgt    = req.wdata;
        `LMX_A_DETEN: ctl_next.det_en = req.wdata;
        default:      ctl_next = ctl_reg;
      endcase
    end
  end

  // read data selection
  always_comb begin
    rd_next = 8'h00;
    if (hit_d0) begin
      rd_next = duty0_reg[a];
    end else if (hit_d1) begin
      rd_next = duty1_reg[a];
    end else if (hit_res) begin
      rd_next = det_reg[8*res_idx +: 8];
    end else if (pg0) begin
      case (a)
        `LMX_A_FAULT: rd_next = {4'h0, fault_reg};
        `LMX_A_CFG:   rd_next = ctl_reg.op_cfg;
        `LMX_A_GCC_R: rd_next = ctl_reg.gcc_r;
        `LMX_A_GCC_G: rd_next = ctl_reg.gcc_g;
        `LMX_A_GCC_B: rd_next = ctl_reg.gcc_b;
        `LMX_A_PULL:  rd_next = ctl_reg.pull;
        `LMX_A_FREQ:  rd_next = ctl_reg.freq;
        `LMX_A_SPRD:  rd_next = ctl_reg.sprd;
        `LMX_A_DGT:   rd_next = ctl_reg.dgt;
        `LMX_A_DETEN: rd_next = ctl_reg.det_en;
        default:      rd_next = 8'h00;
      endcase
    end
  end

  // duty bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 1; i <= int'(P0_LAST); i++) duty0_reg[i] <= 8'h00;
      for (int i = 1; i <= int'(P1_LAST); i++) duty1_reg[i] <= 8'h00;
    end else if (srst) begin
      for (int i = 1; i <= int'(P0_LAST); i++) duty0_reg[i] <= 8'h00;
      for (int i = 1; i <= int'(P1_LAST); i++) duty1_reg[i] <= 8'h00;
    end else if (wr & hit_d0) begin
      duty0_reg[a] <= req.wdata;
    end else if (wr & hit_d1) begin
      duty1_reg[a] <= req.wdata;
    end
  end

  // control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= '{`LMX_RST_ZERO, `LMX_RST_ZERO, `LMX_RST_ZERO, `LMX_RST_ZERO, `LMX_RST_PULL,
                   `LMX_RST_FREQ, `LMX_RST_SPRD, `LMX_RST_ZERO, `LMX_RST_ZERO};
    end else if (srst) begin
      ctl_reg <= '{`LMX_RST_ZERO, `LMX_RST_ZERO, `LMX_RST_ZERO, `LMX_RST_ZERO, `LMX_RST_PULL,
                   `LMX_RST_FREQ, `LMX_RST_SPRD, `LMX_RST_ZERO, `LMX_RST_ZERO};
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // status: sticky faults, set wins over soft reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_reg <= 4'h0;
      det_reg   <= 48'h0;
    end else begin
      fault_reg <= (srst ? 4'h0 : fault_reg) | fault_evt;
      det_reg   <= det_load ? det_result : (srst ? 48'h0 : det_reg);
    end
  end

  // i2c page select and its lock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pgsel_reg <= 1'b0;
      lock_reg  <= 8'h00;
    end else if (srst) begin
      pgsel_reg <= 1'b0;
      lock_reg  <= 8'h00;
    end else if (wr & cmd_lk) begin
      lock_reg <= req.wdata;
    end else if (sel_wr & unlock) begin
      pgsel_reg <= sel_ok ? req.wdata[0] : pgsel_reg;
      lock_reg  <= 8'h00;
    end
  end

  // answer and scan read port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      rd_reg  <= 8'h00;
      drd_reg <= 8'h00;
    end else begin
      ack_reg <= req.valid;
      rd_reg  <= (req.valid & ~req.write) ? rd_next : rd_reg;
      drd_reg <= duty_rd_page ? (dr1_ok ? duty1_reg[duty_rd_addr] : 8'h00)
                              : (dr0_ok ? duty0_reg[duty_rd_addr] : 8'h00);
    end
  end

  assign ack          = ack_reg;
  assign rd_data      = rd_reg;
  assign page_sel     = pgsel_reg;
  assign ctl          = ctl_reg;
  assign duty_rd_data = drd_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  wire rd = req.valid & ~req.write;

  locked_select_a: assert property (sel_wr & ~unlock & ~srst |=> $stable(pgsel_reg))
    else $error("page select changed while locked");
  lock_clear_a: assert property (sel_wr & unlock & ~srst |=> lock_reg == 8'h00)
    else $error("lock not cleared after page select write");
  page_one_a: assert property (sel_ok & req.wdata[0] & ~srst |=> pgsel_reg ##1 pgsel_reg || $past(wr))
    else $error("page one not taken");
  duty_echo_a: assert property (wr & hit_d0 ##1 !req.valid ##1 rd & hit_d0 & a == $past(a, 2)
                                |=> rd_data == $past(req.wdata, 3))
    else $error("duty byte did not read back");
  fault_sticky_a: assert property (~srst |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
    else $error("fault flag fell without reset");
  soft_defaults_a: assert property (srst |=> ctl_reg.pull == `LMX_RST_PULL && ctl_reg.freq == `LMX_RST_FREQ &&
                                    ctl_reg.sprd == `LMX_RST_SPRD && ctl_reg.op_cfg == 8'h00 && !pgsel_reg)
    else $error("soft reset left a register off default");
  bad_page_a: assert property (rd & req.spi & req.spi_page > `LMX_PG1 |=> ack && rd_data == 8'h00)
    else $error("read of an unknown page returned data");
  cfg_write_a: assert property (wr & pg0 & a == `LMX_A_CFG & ~srst |=> ctl_reg.op_cfg == $past(req.wdata))
    else $error("config write not stored");
  ack_timing_a: assert property (req.valid |=> ack ##1 (ack == $past(req.valid)))
    else $error("answer not one cycle after request");

  // control writes land in their own byte
  gcc_r_write_a: assert property (wr & pg0 & a == `LMX_A_GCC_R
                                  |=> ctl_reg.gcc_r == $past(req.wdata))
    else $error("first current setting not stored");
  gcc_g_write_a: assert property (wr & pg0 & a == `LMX_A_GCC_G
                                  |=> ctl_reg.gcc_g == $past(req.wdata))
    else $error("second current setting not stored");
  gcc_b_write_a: assert property (wr & pg0 & a == `LMX_A_GCC_B
                                  |=> ctl_reg.gcc_b == $past(req.wdata))
    else $error("third current setting not stored");
  pull_write_a: assert property (wr & pg0 & a == `LMX_A_PULL
                                 |=> ctl_reg.pull == $past(req.wdata))
    else $error("pull-up control not stored");
  freq_write_a: assert property (wr & pg0 & a == `LMX_A_FREQ
                                 |=> ctl_reg.freq == $past(req.wdata))
    else $error("frequency control not stored");
  sprd_write_a: assert property (wr & pg0 & a == `LMX_A_SPRD
                                 |=> ctl_reg.sprd == $past(req.wdata))
    else $error("spread spectrum control not stored");
  dgt_write_a: assert property (wr & pg0 & a == `LMX_A_DGT
                                |=> ctl_reg.dgt == $past(req.wdata))
    else $error("de-ghost timing not stored");
  det_en_write_a: assert property (wr & pg0 & a == `LMX_A_DETEN
                                   |=> ctl_reg.det_en == $past(req.wdata))
    else $error("detection enable not stored");
  ctl_hold_a: assert property (~(wr & pg0) & ~srst
                               |=> $stable(ctl_reg))
    else $error("control changed without a page 0 write");
  ctl_page1_a: assert property (wr & pg1 & ~srst
                                |=> $stable(ctl_reg))
    else $error("page 1 write reached a control register");

  // fault flags
  fault_set_a: assert property ((|fault_evt)
                                |=> (fault_reg & $past(fault_evt)) == $past(fault_evt))
    else $error("fault event not flagged");
  fault_quiet_a: assert property (~(|fault_evt) & ~srst
                                  |=> fault_reg == $past(fault_reg))
    else $error("fault flags moved without an event");
  fault_read_a: assert property (rd & pg0 & a == `LMX_A_FAULT
                                 |=> rd_data == {4'h0, $past(fault_reg)})
    else $error("fault flags read wrong");

  // detection results
  result_load_a: assert property (det_load
                                  |=> det_reg == $past(det_result))
    else $error("detection result not loaded");
  result_hold_a: assert property (~det_load & ~srst
                                  |=> $stable(det_reg))
    else $error("detection result changed by a write");
  result_low_a: assert property (rd & pg0 & a == `LMX_A_RES_LO
                                 |=> rd_data == $past(det_reg[7:0]))
    else $error("first result byte read wrong");
  result_high_a: assert property (rd & pg0 & a == `LMX_A_RES_HI
                                  |=> rd_data == $past(det_reg[47:40]))
    else $error("last result byte read wrong");

  // soft reset and its lock
  soft_clear_a: assert property (srst & ~det_load & ~(|fault_evt)
                                 |=> fault_reg == 4'h0 && det_reg == 48'h0)
    else $error("soft reset left status set");
  soft_duty_a: assert property (srst
                                |=> duty0_reg[1] == 8'h00 && duty1_reg[1] == 8'h00 && lock_reg == 8'h00)
    else $error("soft reset left a duty byte set");
  soft_guard_a: assert property (wr & pg1 & a == `LMX_A_SRST & ~ctl_reg.op_cfg[`LMX_CFG_RP]
                                 |=> $stable(ctl_reg) && $stable(pgsel_reg))
    else $error("soft reset taken while write locked");
  write_only_a: assert property (rd & pg1 & a == `LMX_A_SRST
                                 |=> rd_data == 8'h00)
    else $error("reset register read back data");

  // duty storage and scan read port
  duty0_store_a: assert property (wr & hit_d0
                                  |=> duty0_reg[$past(a)] == $past(req.wdata))
    else $error("page 0 duty byte not stored");
  duty1_store_a: assert property (wr & hit_d1
                                  |=> duty1_reg[$past(a)] == $past(req.wdata))
    else $error("page 1 duty byte not stored");
  duty_port_a: assert property (~duty_rd_page & dr0_ok
                                |=> duty_rd_data == $past(duty0_reg[duty_rd_addr]))
    else $error("scan port read wrong duty byte");
  duty_port_zero_a: assert property (~duty_rd_page & ~dr0_ok
                                     |=> duty_rd_data == 8'h00)
    else $error("scan port read outside the duty range");

  // page select and its lock
  cmd_read_a: assert property (rd & (cmd_sel | cmd_lk)
                               |=> rd_data == 8'h00)
    else $error("page select slot read back data");
  lock_arm_a: assert property (wr & cmd_lk
                               |=> lock_reg == $past(req.wdata))
    else $error("lock value not stored");
  select_value_a: assert property (sel_wr & unlock & ~sel_ok
                                   |=> $stable(pgsel_reg) && lock_reg == 8'h00)
    else $error("bad page value taken or lock kept");
  spi_no_unlock_a: assert property (wr & req.spi
                                    |=> $past(srst) || ($stable(pgsel_reg) && $stable(lock_reg)))
    else $error("spi write moved the page select");

  soft_reset_c: cover property (srst ##1 req.valid);
  page_swap_c: cover property (wr & cmd_lk & req.wdata == `LMX_LOCK_KEY ##[1:4] sel_ok);
  duty_read_c: cover property (wr & hit_d1 ##[1:8] rd & hit_d1);
  fault_report_c: cover property ((|fault_evt) ##[1:4] rd & pg0 & a == `LMX_A_FAULT);
  result_read_c: cover property (det_load ##[1:4] rd & hit_res);

endmodule

`default_nettype wire
